// [include/fbl_pkg.sv]
package fbl_pkg;
  // ==========================================================
  // Command codes written on the data lines
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK = 8'h01;
  localparam logic [7:0] CMD_UNLOCK = 8'hd0;
  localparam logic [7:0] CMD_LOCKDOWN = 8'h2f;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  // ==========================================================
  // Device map
  localparam int unsigned LOCK_STATE_OFS = 32'h2;
  // ==========================================================
  // Operation status bit positions
  localparam int unsigned ST_READY = 7;
  localparam int unsigned ST_ERASE_ERR = 5;
  localparam int unsigned ST_PROG_ERR = 4;
  localparam int unsigned ST_SUPPLY = 3;
  localparam int unsigned ST_SUSPEND = 2;
  localparam int unsigned ST_LOCK_ERR = 1;
  // ==========================================================
  // Software port map of the controller
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_RESULT = 4'h2;
  localparam logic [3:0] REG_STATE = 4'h3;
  localparam logic [2:0] OP_LOCK = 3'h1;
  localparam logic [2:0] OP_UNLOCK = 3'h2;
  localparam logic [2:0] OP_LOCKDOWN = 3'h3;
  localparam logic [2:0] OP_READ_LOCK = 3'h4;
  localparam logic [2:0] OP_READ_STATUS = 3'h5;
  localparam logic [2:0] OP_CLEAR_STATUS = 3'h6;
  localparam logic [2:0] OP_BAD_SECOND = 3'h7;
  // ==========================================================
  // Bus timing, in ns and in cycles of the 100 ns clock
  localparam int unsigned CLK_NS = 100;
  localparam int unsigned WE_PULSE_NS = 100;
  localparam int unsigned READ_ACCESS_NS = 200;
  localparam int unsigned WE_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RD_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] RESET_DATA = 3'h0;
  typedef enum logic [2:0] {
    FBL_IDLE = 3'b000,
    FBL_SETUP = 3'b001,
    FBL_GAP = 3'b011,
    FBL_SECOND = 3'b010,
    FBL_RD_CMD = 3'b110,
    FBL_READ = 3'b111,
    FBL_DONE = 3'b101
  } fbl_state_t;
endpackage

// [rtl/fbl_host.sv]
// ==========================================================
// Functional notes
// - Lock is 0x60 then 0x01
// - Unlock is 0x60 then 0xD0
// - Lock-down is 0x60 then 0x2F
// - Identify 0x90, read base plus 0x00002
module fbl_host #(
  parameter int unsigned AW = 22
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic [AW-1:0] fl_addr,
  output logic [15:0] fl_dq_out,
  input wire logic [15:0] fl_dq_in,
  output logic fl_dq_oe_n,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output logic fl_wp_n
);
  // Pulse and access lengths in clock cycles
  localparam logic [1:0] WE_N = 2'(fbl_pkg::WE_CYC);
  localparam logic [1:0] RD_N = 2'(fbl_pkg::RD_CYC);

  // ==========================================================
  // Software registers
  fbl_pkg::fbl_state_t st_q, st_d;
  logic [AW-1:0] addr_q;
  logic [2:0] op_q;
  logic wp_q;
  logic busy_q;
  logic done_q;
  logic [15:0] result_q;
  logic [1:0] cnt_q, cnt_d;
  logic [15:0] dq_s1_q, dq_s2_q;
  logic [31:0] rdata_q;

  // ==========================================================
  // Decode
  wire wr_ctrl = sw_wr && (sw_addr == fbl_pkg::REG_CTRL);
  wire wr_addr = sw_wr && (sw_addr == fbl_pkg::REG_ADDR);
  // Op zero means no operation; a start while busy is dropped
  wire start = wr_ctrl && !busy_q && (sw_wdata[2:0] != 3'h0);
  wire is_lock_op = (op_q == fbl_pkg::OP_LOCK) || (op_q == fbl_pkg::OP_UNLOCK)
                    || (op_q == fbl_pkg::OP_LOCKDOWN) || (op_q == fbl_pkg::OP_BAD_SECOND);
  wire is_read_op = (op_q == fbl_pkg::OP_READ_LOCK) || (op_q == fbl_pkg::OP_READ_STATUS);
  wire cnt_end = (cnt_q == 2'h0);
  wire [31:0] rd_mux =
    (sw_addr == fbl_pkg::REG_CTRL) ? {28'h0, wp_q, op_q} :
    (sw_addr == fbl_pkg::REG_ADDR) ? 32'(addr_q) :
    (sw_addr == fbl_pkg::REG_RESULT) ? {16'h0, result_q} :
    (sw_addr == fbl_pkg::REG_STATE) ? {29'h0, st_q == fbl_pkg::FBL_IDLE, done_q, busy_q} :
    32'h0;

  // Second cycle data of a lock sequence
  wire [7:0] second_cmd =
    (op_q == fbl_pkg::OP_LOCK) ? fbl_pkg::CMD_LOCK :
    (op_q == fbl_pkg::OP_UNLOCK) ? fbl_pkg::CMD_UNLOCK :
    (op_q == fbl_pkg::OP_LOCKDOWN) ? fbl_pkg::CMD_LOCKDOWN :
    fbl_pkg::CMD_READ_ARRAY; // deliberate invalid follower for error test
  wire [7:0] first_cmd =
    is_lock_op ? fbl_pkg::CMD_LOCK_SETUP :
    (op_q == fbl_pkg::OP_READ_LOCK) ? fbl_pkg::CMD_READ_ID :
    (op_q == fbl_pkg::OP_CLEAR_STATUS) ? fbl_pkg::CMD_CLEAR_STATUS :
    fbl_pkg::CMD_READ_STATUS;
  // Lock state reads target block base plus the lock offset
  wire [AW-1:0] rd_addr = (op_q == fbl_pkg::OP_READ_LOCK) ?
    (addr_q | AW'(fbl_pkg::LOCK_STATE_OFS)) : addr_q;

  // ==========================================================
  // Sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_end ? 2'h0 : cnt_q - 2'h1;
    case (st_q)
      fbl_pkg::FBL_IDLE: begin
        if (start) begin
          st_d = fbl_pkg::FBL_SETUP;
          cnt_d = WE_N;
        end
      end
      fbl_pkg::FBL_SETUP: begin
        if (cnt_end) begin
          st_d = fbl_pkg::FBL_GAP;
          cnt_d = WE_N;
        end
      end
      fbl_pkg::FBL_GAP: begin
        // Recovery time after the first write cycle, before the second write, the read or done
        if (cnt_end) begin
          if (is_lock_op) begin
            st_d = fbl_pkg::FBL_SECOND;
            cnt_d = WE_N;
          end else if (is_read_op) begin
            st_d = fbl_pkg::FBL_READ;
            cnt_d = RD_N;
          end else begin
            st_d = fbl_pkg::FBL_DONE;
          end
        end
      end
      fbl_pkg::FBL_SECOND: begin
        // No busy wait: lock change is done at end of the pulse
        if (cnt_end) begin
          st_d = fbl_pkg::FBL_RD_CMD;
          cnt_d = WE_N;
        end
      end
      fbl_pkg::FBL_RD_CMD: begin
        if (cnt_end) begin
          st_d = fbl_pkg::FBL_READ;
          cnt_d = RD_N;
        end
      end
      fbl_pkg::FBL_READ: begin
        // Data stand over the whole read, so the flop delay is harmless
        if (cnt_end) begin
          st_d = fbl_pkg::FBL_DONE;
        end
      end
      // One cycle in which busy and done change together
      fbl_pkg::FBL_DONE: st_d = fbl_pkg::FBL_IDLE;
      default: st_d = fbl_pkg::FBL_IDLE;
    endcase
  end

  wire in_wr_pulse = (st_q == fbl_pkg::FBL_SETUP) || (st_q == fbl_pkg::FBL_SECOND);
  // Address held through the gap of a two-cycle sequence
  wire in_wr_phase = in_wr_pulse || (st_q == fbl_pkg::FBL_GAP && is_lock_op);
  // Byte held after each pulse until the next state takes over
  wire [7:0] cmd_now = (st_q == fbl_pkg::FBL_SETUP) ? first_cmd :
    (st_q == fbl_pkg::FBL_RD_CMD) ? fbl_pkg::CMD_READ_STATUS : second_cmd;
  // Lock changes are read back through status so errors are visible
  // Data lines come from outside: two flops before any use
  wire [15:0] captured = dq_s2_q;

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= fbl_pkg::FBL_IDLE;
      cnt_q <= 2'h0;
      addr_q <= '0;
      op_q <= 3'h0;
      wp_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      result_q <= 16'h0;
      dq_s1_q <= 16'h0;
      dq_s2_q <= 16'h0;
      rdata_q <= 32'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      dq_s1_q <= fl_dq_in;
      dq_s2_q <= dq_s1_q;
      // Zero outside the cycle after a read strobe
      rdata_q <= sw_rd ? rd_mux : 32'h0;
      if (wr_addr) begin
        addr_q <= sw_wdata[AW-1:0];
      end
      if (wr_ctrl) begin
        wp_q <= sw_wdata[3];
      end
      if (start) begin
        op_q <= sw_wdata[2:0];
        busy_q <= 1'b1;
      end else if (st_q == fbl_pkg::FBL_DONE) begin
        busy_q <= 1'b0;
      end
      // Done set wins over clear by a new start
      if (st_q == fbl_pkg::FBL_DONE) begin
        done_q <= 1'b1;
      end else if (start) begin
        done_q <= 1'b0;
      end
      if (st_q == fbl_pkg::FBL_READ && cnt_end) begin
        // Lock code {pin, lockdown, lock}; status kept whole in low byte
        result_q <= (op_q == fbl_pkg::OP_READ_LOCK) ?
          {13'h0, wp_q, captured[1], captured[0]} :
          {8'h0, captured[7:0]};
      end
    end
  end

  // ==========================================================
  // Flash pins
  // Chip stays selected from the first pulse to the end of the read, or of the gap for clear status
  wire active = (st_q != fbl_pkg::FBL_IDLE) && (st_q != fbl_pkg::FBL_DONE);
  wire rd_phase = (st_q == fbl_pkg::FBL_READ);
  assign fl_ce_n = !active;
  // Pulse ends one cycle before its state, so the byte still stands as the line rises
  wire wr_state = in_wr_pulse || (st_q == fbl_pkg::FBL_RD_CMD);
  wire we_low = wr_state && !cnt_end;
  assign fl_we_n = !we_low;
  assign fl_oe_n = !rd_phase;
  assign fl_dq_oe_n = rd_phase || !active;
  assign fl_dq_out = {8'h0, cmd_now};
  assign fl_addr = (rd_phase || in_wr_phase) ? rd_addr : addr_q;
  assign fl_wp_n = wp_q;
  assign sw_rdata = rdata_q;
endmodule

// [testbench/fbl_host_chk.sv]
module fbl_host_chk #(
  parameter int unsigned AW = 22
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [AW-1:0] fl_addr,
  input wire logic [15:0] fl_dq_out,
  input wire logic fl_dq_oe_n,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic we_q;
  logic new_cmd;
  logic [7:0] last_q;
  // A new command is a fresh low pulse or a new byte within one
  assign new_cmd = !fl_we_n && (we_q || fl_dq_out[7:0] != last_q);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      we_q <= 1'b1;
      last_q <= 8'hff;
    end else begin
      we_q <= fl_we_n;
      if (new_cmd) begin
        last_q <= fl_dq_out[7:0];
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_first_cmd: assert property (new_cmd && last_q != 8'h60 |-> fl_dq_out[7:0] inside {8'h60, 8'h90, 8'h70, 8'h50})
    else $error("unknown first command byte");
  a_second_cmd: assert property (new_cmd && last_q == 8'h60 |-> fl_dq_out[7:0] inside {8'h01, 8'hd0, 8'h2f, 8'hff})
    else $error("bad byte after lock setup");
  a_write_drive: assert property (!fl_we_n |-> !fl_ce_n && !fl_dq_oe_n && fl_dq_out[15:8] == 8'h00)
    else $error("write pulse without driven data");
  a_id_addr: assert property (!fl_oe_n && last_q == 8'h90 |-> fl_addr[1:0] == 2'b10 && fl_dq_oe_n)
    else $error("lock code read at wrong offset");
  c_lock: cover property (new_cmd && last_q == 8'h60 && fl_dq_out[7:0] == 8'h01);
  c_lockdown: cover property (new_cmd && last_q == 8'h60 && fl_dq_out[7:0] == 8'h2f);
  c_bad: cover property (new_cmd && last_q == 8'h60 && fl_dq_out[7:0] == 8'hff);
endmodule
bind fbl_host fbl_host_chk #(.AW(AW)) u_chk (.clk_sys, .rst, .fl_addr, .fl_dq_out, .fl_dq_oe_n, .fl_ce_n, .fl_we_n,
  .fl_oe_n);

// [testbench/fbl_flash_model.sv]
module fbl_flash_model #(
  parameter int unsigned AW = 22,
  parameter int unsigned BLK_LSB = 15
) (
  input wire logic rst,
  input wire logic [AW-1:0] fl_addr,
  input wire logic [15:0] fl_dq_out,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  input wire logic fl_wp_n,
  output logic [15:0] fl_dq_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lk_q, ld_q, lk_v, st_q;
  logic setup_q, id_q;
  logic [2:0] blk;
  logic [15:0] val;
  assign blk = fl_addr[BLK_LSB+2:BLK_LSB];
  assign lk_v = lk_q | (ld_q & {8{~fl_wp_n}});
  assign val = id_q ? {14'h0, ld_q[blk], lk_v[blk]} : {8'h0, st_q};
  // Released lines show the inverse so a stale value cannot pass
  assign fl_dq_in = (!fl_ce_n && !fl_oe_n) ? val : ~val;
  always @(posedge fl_we_n or posedge rst) begin
    if (rst) begin
      lk_q = 8'hff;
      ld_q = 8'h00;
      st_q = 8'h80;
      setup_q = 1'b0;
      id_q = 1'b0;
    end else if (!fl_ce_n) begin
      lk_q = lk_v;
      id_q = !setup_q && fl_dq_out[7:0] == 8'h90;
      if (setup_q) begin
        case (fl_dq_out[7:0])
          8'h01: lk_q[blk] = 1'b1;
          8'hd0: lk_q[blk] = lk_q[blk] & ld_q[blk] & ~fl_wp_n;
          8'h2f: begin
            ld_q[blk] = 1'b1;
            lk_q[blk] = 1'b1;
          end
          default: st_q[5:4] = 2'b11;
        endcase
        setup_q = 1'b0;
      end else begin
        setup_q = fl_dq_out[7:0] == 8'h60;
        st_q = (fl_dq_out[7:0] == 8'h50) ? 8'h80 : st_q;
      end
    end
  end
endmodule

// [testbench/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [3:0] ctl; logic [2:0] blk; logic [7:0] code;} fbl_row_t;
  logic clk_sys = 1'b0, rst = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0, sw_rdata, v;
  logic [21:0] fl_addr;
  logic [15:0] fl_dq_out, fl_dq_in;
  logic fl_ce_n, fl_we_n, fl_oe_n, fl_wp_n;
  int err_total = 0, cmp_count = 0;
  // ==========================================================
  // Rows: wp and op, block, expected lock code
  fbl_row_t rows [12] = '{'{4'h4, 3'h0, 8'h01}, '{4'h2, 3'h0, 8'h00}, '{4'h1, 3'h0, 8'h01}, '{4'h2, 3'h1, 8'h00},
    '{4'h4, 3'h0, 8'h01}, '{4'h3, 3'h1, 8'h03}, '{4'h2, 3'h1, 8'h03}, '{4'ha, 3'h1, 8'h06},
    '{4'h9, 3'h1, 8'h07}, '{4'ha, 3'h1, 8'h06}, '{4'h4, 3'h1, 8'h03}, '{4'h7, 3'h2, 8'h01}};
  fbl_host uut (.clk_sys(clk_sys), .rst(rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_in(fl_dq_in), .fl_dq_oe_n(),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_wp_n(fl_wp_n));
  fbl_flash_model dev (.rst(rst), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n), .fl_wp_n(fl_wp_n), .fl_dq_in(fl_dq_in));
  always #50 clk_sys = ~clk_sys;
  task complete_run();
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask
  // Starts one operation, polls done under a bound, then fetches RESULT
  task run(input logic [3:0] ctl, input logic [2:0] blk);
    wr(fbl_pkg::REG_ADDR, {14'h0, blk, 15'h0});
    wr(fbl_pkg::REG_CTRL, {28'h0, ctl});
    v = 32'h0;
    for (int i = 0; i < 80 && v[1] !== 1'b1; i++) begin
      rd(fbl_pkg::REG_STATE);
    end
    chk(v[7:0], 8'h06);
    rd(fbl_pkg::REG_RESULT);
  endtask
  initial begin
    #1000000;
    err_total++;
    complete_run();
  end
  initial begin
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    rd(fbl_pkg::REG_STATE);
    chk(v[7:0], 8'h04);
    for (int i = 0; i < 12; i++) begin
      run(rows[i].ctl, rows[i].blk);
      run({rows[i].ctl[3], 3'h4}, rows[i].blk);
      chk(v[7:0] & 8'h07, rows[i].code);
    end
    run(4'h5, 3'h2);
    chk(v[7:0] & 8'hb0, 8'hb0);
    run(4'h6, 3'h2);
    run(4'h5, 3'h2);
    chk(v[7:0], 8'h80);
    // An unlock written while busy must be dropped
    wr(fbl_pkg::REG_ADDR, {14'h0, 3'h2, 15'h0});
    wr(fbl_pkg::REG_CTRL, 32'h5);
    wr(fbl_pkg::REG_CTRL, 32'h2);
    repeat (20) @(posedge clk_sys);
    run(4'h4, 3'h2);
    chk(v[7:0] & 8'h07, 8'h01);
    wr(4'h9, 32'hffff_ffff);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(fbl_pkg::REG_STATE);
    chk(v[7:0], 8'h04);
    run(4'h4, 3'h1);
    chk(v[7:0] & 8'h07, 8'h01);
    complete_run();
  end
endmodule
